// >>> design/pwrctl_defs.svh
// Purpose: offsets, fields, reset values and timing counts of the power and clock control block
// Assumes: APB with 32-bit data, 100 MHz clock
// Notes:   times are given in their own unit; the wake cycle counts derive from them, the startup count is given in cycles
`ifndef PWRCTL_DEFS_SVH
`define PWRCTL_DEFS_SVH

`define CLK_FREQ_MHZ        100
`define SLEEP_WAKE_US       100
`define SLEEP_WAKE_CYC      (`SLEEP_WAKE_US * `CLK_FREQ_MHZ)
`define PDN_WAKE_MS         10
`define PDN_WAKE_CYC        (`PDN_WAKE_MS * 1000 * `CLK_FREQ_MHZ)
`define STARTUP_CYC         64

`define OFS_CTRL            12'h000
`define OFS_CHAN            12'h004
`define OFS_CMODE           12'h008
`define OFS_STATUS          12'h00C
`define OFS_SAMPLE_IN       12'h010
`define OFS_SAMPLE_OUT      12'h014

`define CTRL_SOFT_RESET     0
`define CTRL_SLEEP          1
`define CTRL_LOW_POWER      2
`define CTRL_XCLK_EN        3
`define CTRL_REFCORR_EN     4
`define CTRL_CM_BUF_OFF     5
`define CTRL_CM_SRC         6

`define CMODE_DIV_LSB       0
`define CMODE_DIV_W         5
`define CMODE_DIV_RESET     5'h0A

`define CODE_POS_MAX        24'h7FFFFF
`define CODE_NEG_MAX        24'h800000

`endif

// >>> design/pwrctl_pkg.sv
// Purpose: types shared by the power and clock control block
// Assumes: nothing beyond the defs header
// Notes:   straps and register settings travel as two separate structs
`default_nettype none
package pwrctl_pkg;
	typedef enum logic [2:0] {ST_OSC_START, ST_RUN, ST_SLEEP, ST_WAKE, ST_PDN, ST_PDN_WAKE} pstate_t;
	typedef struct packed {
		logic register_mode;
		logic crystal_source;
	} straps_t;
	typedef struct packed {
		logic       cm_buf_off;
		logic       cm_source;
		logic [4:0] cm_div;
		logic       xclk_en;
		logic       refcorr_en;
		logic       low_power;
		logic       sleep;
		logic [3:0] chan_off;
	} config_t;
endpackage
`default_nettype wire

// >>> design/adc_power_clock_mode_control.sv
// Purpose: strap capture, clock handover, common-mode, channel, sleep and power-down control
// Assumes: APB slave, 100 MHz CLK_IN, straps and power-down pin asynchronous to CLK_IN
// Notes:   analog quantities are given as codes and enables for the analog macros
//
// Notes on behaviour
// - strap selects pin or register configuration
// - result is 24-bit two's complement, MSB first
// - result saturates at 0x7FFFFF and 0x800000
// - pin mode: common-mode on, half reference
// - register mode: common-mode level programmable
// - buffer off makes common-mode pin high-Z
// - reference correction only when enabled, register mode
// - correction tracks quarter current per off channel
// - run on oscillator, then hand over clock
// - clock-source strap picks crystal or CMOS
// - pin mode: crystal output follows crystal source
// - register mode: crystal output off until enabled
// - low power halves modulator clock
// - each channel has its own power-off bit
// - sleep powers down all, registers kept; crystal oscillator and digital regulator stay on
// - sleep exit ready within 100 us
// - power-down pin low powers everything down
// - power-down exit resets registers, 10 ms wait
// - reset pin or soft reset restores defaults; the reset pin loads divider 0 into the register, not 0x0A
//
// Implementation choices: the APB slave port and the address map.
`include "pwrctl_defs.svh"
`default_nettype none
module adc_power_clock_mode_control #(
	parameter int unsigned PDN_WAKE_CYCLES = `PDN_WAKE_CYC
) (
	input  wire logic        CLK_IN,
	input  wire logic        RESETN_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [11:0] PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	input  wire logic        MODE_SELECT_PIN_IN,
	input  wire logic        CLOCK_SOURCE_SELECT_PIN_IN,
	input  wire logic        POWER_DOWN_PIN_N_IN,
	output logic             USE_EXTERNAL_CLOCK_OUT,
	output logic             CRYSTAL_CLOCK_BUFFER_EN_OUT,
	output logic             CRYSTAL_OSC_EN_OUT,
	output logic             MOD_HALF_RATE_OUT,
	output logic             COMMON_MODE_OUTPUT_OE_OUT,
	output logic             COMMON_MODE_SOURCE_OUT,
	output logic      [4:0]  COMMON_MODE_DIVIDER_SELECT_OUT,
	output logic             REFERENCE_DROP_CORRECT_OUT,
	output logic      [2:0]  REFERENCE_CURRENT_QUARTERS_OUT,
	output logic      [3:0]  CHANNEL_POWER_ON_OUT,
	output logic             DIGITAL_REG_ON_OUT,
	output logic             READY_OUT
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [2:0] mode_sync_q;
	logic [2:0] csel_sync_q;
	logic [2:0] pdn_sync_q;
	logic       pdn_low_q;

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			mode_sync_q <= 3'h0;
			csel_sync_q <= 3'h0;
			pdn_sync_q  <= 3'h7;
			pdn_low_q   <= 1'b0;
		end else begin
			mode_sync_q <= {mode_sync_q[1:0], MODE_SELECT_PIN_IN};
			csel_sync_q <= {csel_sync_q[1:0], CLOCK_SOURCE_SELECT_PIN_IN};
			pdn_sync_q  <= {pdn_sync_q[1:0], POWER_DOWN_PIN_N_IN};
			if (pdn_sync_q[2] == pdn_sync_q[1])
				pdn_low_q <= !pdn_sync_q[1];
		end
	end

	// ----------------------------------------
	// power state machine
	// ----------------------------------------
	pwrctl_pkg::pstate_t state_q;
	logic [31:0]         wait_q;
	logic                capture_q;
	pwrctl_pkg::straps_t straps_q;
	pwrctl_pkg::config_t cfg_q;
	logic                soft_reset_q;
	logic                wait_done;

	assign wait_done = (wait_q == 32'h00000000);

	// settle the strap synchronisers before they are sampled
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			state_q   <= pwrctl_pkg::ST_OSC_START;
			wait_q    <= 32'(`STARTUP_CYC);
			capture_q <= 1'b1;
		end else begin
			capture_q <= 1'b0;
			if (!wait_done)
				wait_q <= wait_q - 32'h00000001;
			if (pdn_low_q && state_q != pwrctl_pkg::ST_PDN) begin
				state_q <= pwrctl_pkg::ST_PDN;
			end else begin
				unique case (state_q)
				pwrctl_pkg::ST_OSC_START: begin
					if (wait_done)
						state_q <= pwrctl_pkg::ST_RUN;
				end
				pwrctl_pkg::ST_RUN: begin
					if (cfg_q.sleep && straps_q.register_mode)
						state_q <= pwrctl_pkg::ST_SLEEP;
				end
				pwrctl_pkg::ST_SLEEP: begin
					if (!cfg_q.sleep) begin
						state_q <= pwrctl_pkg::ST_WAKE;
						wait_q  <= 32'(`SLEEP_WAKE_CYC - 1);
					end
				end
				pwrctl_pkg::ST_WAKE: begin
					if (wait_done)
						state_q <= pwrctl_pkg::ST_RUN;
				end
				pwrctl_pkg::ST_PDN: begin
					if (!pdn_low_q) begin
						state_q   <= pwrctl_pkg::ST_PDN_WAKE;
						wait_q    <= PDN_WAKE_CYCLES - 32'h00000001;
						capture_q <= 1'b1;
					end
				end
				pwrctl_pkg::ST_PDN_WAKE: begin
					if (wait_done)
						state_q <= pwrctl_pkg::ST_RUN;
				end
				endcase
			end
		end
	end

	// straps are taken from the settled synchronisers on capture and on every cycle of the startup wait
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			straps_q <= '0;
		end else if (capture_q || (state_q == pwrctl_pkg::ST_OSC_START && !wait_done)) begin
			straps_q.register_mode  <= mode_sync_q[2];
			straps_q.crystal_source <= csel_sync_q[2];
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic        wr_en;
	logic        rd_en;
	logic [23:0] sample_q;
	logic [23:0] sample_out_q;
	logic        reg_clear;

	assign wr_en     = PSEL_IN && PENABLE_IN && PWRITE_IN;
	assign rd_en     = PSEL_IN && PENABLE_IN && !PWRITE_IN;
	assign reg_clear = soft_reset_q || pdn_low_q;
	assign PREADY_OUT = 1'b1;

	function automatic logic [23:0] saturate(input logic [31:0] raw);
		if (!raw[31] && raw[30:23] != 8'h00)
			return `CODE_POS_MAX;
		else if (raw[31] && raw[30:23] != 8'hFF)
			return `CODE_NEG_MAX;
		else
			return raw[23:0];
	endfunction

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			cfg_q        <= '0;
			soft_reset_q <= 1'b0;
			sample_q     <= 24'h000000;
		end else if (reg_clear) begin
			cfg_q        <= '0;
			cfg_q.cm_div <= `CMODE_DIV_RESET;
			soft_reset_q <= 1'b0; // self clearing
			sample_q     <= 24'h000000;
		end else if (wr_en && straps_q.register_mode) begin
			unique case (PADDR_IN)
			`OFS_CTRL: begin
				soft_reset_q     <= PWDATA_IN[`CTRL_SOFT_RESET];
				cfg_q.sleep      <= PWDATA_IN[`CTRL_SLEEP];
				cfg_q.low_power  <= PWDATA_IN[`CTRL_LOW_POWER];
				cfg_q.xclk_en    <= PWDATA_IN[`CTRL_XCLK_EN];
				cfg_q.refcorr_en <= PWDATA_IN[`CTRL_REFCORR_EN];
				cfg_q.cm_buf_off <= PWDATA_IN[`CTRL_CM_BUF_OFF];
				cfg_q.cm_source  <= PWDATA_IN[`CTRL_CM_SRC];
			end
			`OFS_CHAN:      cfg_q.chan_off <= PWDATA_IN[3:0];
			`OFS_CMODE:     cfg_q.cm_div <= PWDATA_IN[`CMODE_DIV_LSB +: `CMODE_DIV_W];
			`OFS_SAMPLE_IN: sample_q <= saturate(PWDATA_IN);
			default: ;
			endcase
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	logic [31:0] rdata_d;

	always_comb begin
		rdata_d = 32'h00000000;
		unique case (PADDR_IN)
		`OFS_CTRL:       rdata_d[6:1] = {cfg_q.cm_source, cfg_q.cm_buf_off, cfg_q.refcorr_en,
						 cfg_q.xclk_en, cfg_q.low_power, cfg_q.sleep};
		`OFS_CHAN:       rdata_d[3:0] = cfg_q.chan_off;
		`OFS_CMODE:      rdata_d[4:0] = cfg_q.cm_div;
		`OFS_STATUS:     rdata_d[5:0] = {READY_OUT, 2'(state_q == pwrctl_pkg::ST_SLEEP),
						 straps_q.crystal_source, straps_q.register_mode,
						 USE_EXTERNAL_CLOCK_OUT};
		`OFS_SAMPLE_IN:  rdata_d = {{8{sample_q[23]}}, sample_q};
		`OFS_SAMPLE_OUT: rdata_d = {sample_out_q, 8'h00};
		default:         rdata_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN)
			sample_out_q <= 24'h000000;
		else
			sample_out_q <= sample_q;
	end

	assign PRDATA_OUT  = rd_en ? rdata_d : 32'h00000000;
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && (PADDR_IN > `OFS_SAMPLE_OUT || PADDR_IN[1:0] != 2'h0);

	// ----------------------------------------
	// analog controls
	// ----------------------------------------
	logic running;
	logic rm;
	logic [2:0] off_count;

	assign running = (state_q == pwrctl_pkg::ST_RUN);
	assign rm      = straps_q.register_mode;
	assign off_count = 3'(cfg_q.chan_off[0]) + 3'(cfg_q.chan_off[1])
			 + 3'(cfg_q.chan_off[2]) + 3'(cfg_q.chan_off[3]);

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			USE_EXTERNAL_CLOCK_OUT         <= 1'b0;
			CRYSTAL_CLOCK_BUFFER_EN_OUT    <= 1'b0;
			CRYSTAL_OSC_EN_OUT             <= 1'b0;
			MOD_HALF_RATE_OUT              <= 1'b0;
			COMMON_MODE_OUTPUT_OE_OUT      <= 1'b0;
			COMMON_MODE_SOURCE_OUT         <= 1'b0;
			COMMON_MODE_DIVIDER_SELECT_OUT <= `CMODE_DIV_RESET;
			REFERENCE_DROP_CORRECT_OUT     <= 1'b0;
			REFERENCE_CURRENT_QUARTERS_OUT <= 3'h4;
			CHANNEL_POWER_ON_OUT           <= 4'h0;
			DIGITAL_REG_ON_OUT             <= 1'b1;
			READY_OUT                      <= 1'b0;
		end else begin
			USE_EXTERNAL_CLOCK_OUT <= !pdn_low_q && state_q != pwrctl_pkg::ST_OSC_START;
			CRYSTAL_OSC_EN_OUT     <= !pdn_low_q && straps_q.crystal_source;
			CRYSTAL_CLOCK_BUFFER_EN_OUT <= running
				&& straps_q.crystal_source && (rm ? cfg_q.xclk_en : 1'b1);
			MOD_HALF_RATE_OUT      <= rm && cfg_q.low_power;
			COMMON_MODE_OUTPUT_OE_OUT <= running && !(rm && cfg_q.cm_buf_off);
			COMMON_MODE_SOURCE_OUT <= rm && cfg_q.cm_source;
			COMMON_MODE_DIVIDER_SELECT_OUT <= rm ? cfg_q.cm_div : `CMODE_DIV_RESET;
			REFERENCE_DROP_CORRECT_OUT <= running && rm && cfg_q.refcorr_en;
			REFERENCE_CURRENT_QUARTERS_OUT <= rm ? 3'(3'h4 - off_count) : 3'h4;
			CHANNEL_POWER_ON_OUT   <= running ? (rm ? ~cfg_q.chan_off : 4'hF) : 4'h0;
			DIGITAL_REG_ON_OUT     <= !pdn_low_q;
			READY_OUT              <= running;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence pdn_seen;
		pdn_low_q ##1 !pdn_low_q;
	endsequence

	// regulator follows the filtered power-down level pdn_low_q one cycle later, channels one more via the state
	chk_pdn_all_off: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		pdn_low_q |=> !DIGITAL_REG_ON_OUT ##1 (CHANNEL_POWER_ON_OUT == 4'h0))
		else $error("channels on during power-down");
	chk_pdn_wake_wait: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		pdn_seen |-> ##1 (state_q == pwrctl_pkg::ST_PDN_WAKE && wait_q == PDN_WAKE_CYCLES - 1))
		else $error("power-down wake wait not loaded");
	chk_pdn_regs_clear: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		pdn_low_q |=> (cfg_q.chan_off == 4'h0 && !cfg_q.sleep))
		else $error("registers kept over power-down");
	chk_sleep_wake_time: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(state_q == pwrctl_pkg::ST_SLEEP && !cfg_q.sleep && !pdn_low_q)
		|=> (wait_q == `SLEEP_WAKE_CYC - 1))
		else $error("sleep wake time wrong");
	chk_sleep_keeps_cfg: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(state_q == pwrctl_pkg::ST_SLEEP && !reg_clear && !wr_en) |=> $stable(cfg_q))
		else $error("register lost in sleep");
	chk_refcorr_pin: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		!rm |=> !REFERENCE_DROP_CORRECT_OUT)
		else $error("correction active in pin mode");
	chk_xclk_pin_mode: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(running && !rm && straps_q.crystal_source) |=> CRYSTAL_CLOCK_BUFFER_EN_OUT)
		else $error("crystal output off in pin mode");
	chk_straps_hold: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		running |=> $stable(straps_q))
		else $error("strap changed while running");
	chk_cm_fixed_pin: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(running && !rm) |=> (COMMON_MODE_OUTPUT_OE_OUT
			&& COMMON_MODE_DIVIDER_SELECT_OUT == `CMODE_DIV_RESET))
		else $error("common-mode not fixed in pin mode");
	chk_soft_reset: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		soft_reset_q |=> (!soft_reset_q && cfg_q.chan_off == 4'h0))
		else $error("soft reset did not clear");
endmodule
`default_nettype wire

// >>> tb/host_pins.sv
// Purpose: host-side model that drives the straps and the power-down pin
// Assumes: one clock; the bench requests levels, the model moves the pins
// Notes:   pins change just after a rising edge, as a board controller would
`default_nettype none
module host_pins (
	input  wire logic clk_in,
	input  wire logic reg_mode_req_in,
	input  wire logic crystal_req_in,
	input  wire logic power_down_req_in,
	output logic      mode_pin_out,
	output logic      clock_source_pin_out,
	output logic      power_down_pin_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic mode_q = 1'b0;
	logic xtal_q = 1'b0;
	logic pdn_n_q = 1'b1;
	// --------------------------------------------------------------
	// pin drivers
	// --------------------------------------------------------------
	// straps stay put unless the bench asks, so power-up capture sees a steady level
	always @(posedge clk_in) begin
		mode_q <= reg_mode_req_in;
		xtal_q <= crystal_req_in;
	end
	// power-down is a level held low for as long as it is wanted
	always @(posedge clk_in) begin
		pdn_n_q <= ~power_down_req_in;
	end
	assign mode_pin_out         = mode_q;
	assign clock_source_pin_out = xtal_q;
	assign power_down_pin_n_out = pdn_n_q;
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the power and clock control block
// Assumes: zero-wait APB slave, power-down wake count shortened to 100
// Notes:   straps and the power-down pin come from the host pin model
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, mode_pin, src_pin, pdn_n;
	logic        mode_req = 1'b0;
	logic        xtal_req = 1'b0;
	logic        pdn_req = 1'b0;
	logic        ext_clk, xbuf_en, osc_en, half_rate, cm_oe, cm_src, corr, dreg, rdy;
	logic [4:0]  cm_div;
	logic [2:0]  quarters;
	logic [3:0]  chan_on;
	int          errors = 0;
	int          num_checks = 0;
	always #5 clk_in = ~clk_in;
	host_pins i_host_pins (.clk_in(clk_in), .reg_mode_req_in(mode_req),
		.crystal_req_in(xtal_req), .power_down_req_in(pdn_req), .mode_pin_out(mode_pin),
		.clock_source_pin_out(src_pin), .power_down_pin_n_out(pdn_n));
	adc_power_clock_mode_control #(.PDN_WAKE_CYCLES(100)) i_adc_power_clock_mode_control (
		.CLK_IN(clk_in), .RESETN_IN(resetn), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .MODE_SELECT_PIN_IN(mode_pin),
		.CLOCK_SOURCE_SELECT_PIN_IN(src_pin), .POWER_DOWN_PIN_N_IN(pdn_n),
		.USE_EXTERNAL_CLOCK_OUT(ext_clk), .CRYSTAL_CLOCK_BUFFER_EN_OUT(xbuf_en),
		.CRYSTAL_OSC_EN_OUT(osc_en), .MOD_HALF_RATE_OUT(half_rate),
		.COMMON_MODE_OUTPUT_OE_OUT(cm_oe), .COMMON_MODE_SOURCE_OUT(cm_src),
		.COMMON_MODE_DIVIDER_SELECT_OUT(cm_div), .REFERENCE_DROP_CORRECT_OUT(corr),
		.REFERENCE_CURRENT_QUARTERS_OUT(quarters), .CHANNEL_POWER_ON_OUT(chan_on),
		.DIGITAL_REG_ON_OUT(dreg), .READY_OUT(rdy));
	// --------------------------------------------------------------
	// tasks
	// --------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do begin
			@(posedge clk_in);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp, what);
	endtask
	task automatic wait_ready(input int lim);
		int n;
		n = 0;
		while (rdy !== 1'b1 && n < lim) begin
			@(posedge clk_in);
			n++;
		end
		chk({31'h0, rdy}, 32'h1, "ready in time");
	endtask
	task automatic do_reset(input logic m, input logic x);
		@(posedge clk_in);
		mode_req <= m;
		xtal_req <= x;
		resetn <= 1'b0;
		repeat (2) @(posedge clk_in);
		resetn <= 1'b1;
		wait_ready(200);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk_in);
		errors++;
		complete_run();
	end
	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic        e;
		do_reset(1'b0, 1'b1);
		chk({31'h0, ext_clk}, 32'h1, "clock handover");
		chk({31'h0, osc_en}, 32'h1, "crystal osc on");
		chk({31'h0, xbuf_en}, 32'h1, "pin mode crystal out");
		chk({26'h0, cm_oe, cm_div}, 32'h2A, "pin mode common mode");
		wr(12'h000, 32'h0000_0010);
		repeat (3) @(posedge clk_in);
		chk({31'h0, corr}, 32'h0, "pin mode correction off");
		rd(12'h00C, 32'h0000_0025, "status mode");
		do_reset(1'b1, 1'b1);
		chk({30'h0, osc_en, xbuf_en}, 32'h2, "crystal on, out off by default");
		wr(12'h000, 32'h0000_0058);
		wr(12'h008, 32'h0000_0013);
		repeat (3) @(posedge clk_in);
		chk({26'h0, cm_src, cm_div}, 32'h33, "common mode level");
		chk({30'h0, xbuf_en, corr}, 32'h3, "out enable, correction");
		wr(12'h000, 32'h0000_0024);
		repeat (3) @(posedge clk_in);
		chk({30'h0, cm_oe, half_rate}, 32'h1, "buffer off, half rate");
		for (int i = 0; i < 16; i++) begin
			wr(12'h004, i);
			repeat (3) @(posedge clk_in);
			chk({28'h0, chan_on}, {28'h0, ~i[3:0]}, "channel power");
			chk({29'h0, quarters}, 4 - $countones(i[3:0]), "reference quarters");
		end
		wr(12'h004, 32'h0);
		wr(12'h010, 32'h7FFF_FFFF);
		rd(12'h010, 32'h007F_FFFF, "positive limit");
		wr(12'h010, 32'h8000_0000);
		rd(12'h010, 32'hFF80_0000, "negative limit");
		wr(12'h010, 32'hFFFF_FFFF);
		rd(12'h014, 32'hFFFF_FF00, "word msb aligned");
		apb(1'b0, 12'h018, 32'h0, r, e);
		chk({e, r[30:0]}, 32'h8000_0000, "unmapped read");
		mode_req <= 1'b0;
		repeat (4) @(posedge clk_in);
		rd(12'h00C, 32'h0000_0027, "strap kept");
		mode_req <= 1'b1;
		wr(12'h000, 32'h0000_0002);
		repeat (6) @(posedge clk_in);
		chk({27'h0, chan_on, dreg}, 32'h1, "sleep");
		rd(12'h008, 32'h0000_0013, "sleep keeps registers");
		wr(12'h000, 32'h0);
		repeat (100) @(posedge clk_in);
		chk({31'h0, rdy}, 32'h0, "still waking");
		wait_ready(10100);
		wr(12'h000, 32'h0000_0002);
		repeat (6) @(posedge clk_in);
		pdn_req <= 1'b1;
		repeat (8) @(posedge clk_in);
		chk({29'h0, dreg, ext_clk, rdy}, 32'h0, "full power-down");
		chk({27'h0, chan_on, cm_oe}, 32'h0, "power-down wins");
		pdn_req <= 1'b0;
		repeat (50) @(posedge clk_in);
		chk({31'h0, rdy}, 32'h0, "power-up wait");
		wait_ready(400);
		rd(12'h008, 32'h0000_000A, "defaults after power-down");
		wr(12'h008, 32'h0000_0005);
		wr(12'h000, 32'h0000_0001);
		repeat (3) @(posedge clk_in);
		rd(12'h008, 32'h0000_000A, "soft reset defaults");
		rd(12'h000, 32'h0, "soft reset clears");
		do_reset(1'b0, 1'b0);
		chk({30'h0, osc_en, xbuf_en}, 32'h0, "pin mode cmos, out off");
		complete_run();
	end
endmodule
`default_nettype wire
